//--- verilog/msb_top.sv
// The implementer's own choices: the placing of the registers and the APB register port.
`timescale 1ns/1ns
`default_nettype none
// Behaviour
// RULE_01 - group-one, safe state, servo-off use group-one select
// RULE_02 - overtravel uses overtravel select
// RULE_03 - group-two alarms use group-two select
// RULE_04 - reverse brake forces zero speed reference and bypasses soft start
// RULE_05 - reverse brake torque capped by limit and motor maximum torque
// RULE_06 - group-two select 5 warns; alarm still needs manual reset
// RULE_07 - brake engages on servo-off or alarm
// RULE_08 - brake routed to a pair only when its field holds 4
// RULE_09 - stopped servo-off: brake at once, power off after wait
// RULE_10 - positive servo-on wait: brake release first
// RULE_11 - negative servo-on wait: power first
// RULE_12 - alarm removes power at once, servo-off wait ignored
// RULE_13 - running stop: brake when slow or wait elapsed
// RULE_14 - threshold 10..100 rpm default 100; wait 10..100 x10ms default 50
// RULE_15 - host waits 50 ms plus brake release before motion reference
// RULE_16 - zero clamp closes position loop at zero reference
// RULE_17 - stop selects caught at reset; other settings act when written
// RULE_18 - absolute speed compared against threshold
module msb_top
  import msb_pkg::*;
#(
  parameter int P_TICK_CYCLES = MSB_TICK_CYCLES,
  parameter int P_SPD_W       = 16
) (
  input  wire logic               i_clk,
  input  wire logic               i_rst_n,
  input  wire logic               i_ce,
  input  wire logic               i_psel,
  input  wire logic               i_penable,
  input  wire logic               i_pwrite,
  input  wire logic [7:0]         i_paddr,
  input  wire logic [31:0]        i_pwdata,
  output logic                    o_pready,
  output logic [31:0]             o_prdata,
  output logic                    o_pslverr,
  input  wire logic               i_alarm_group_one,
  input  wire logic               i_alarm_group_two,
  input  wire logic               i_safe_state,
  input  wire logic               i_overtravel,
  input  wire logic [1:0]         i_group_one_stop_select,
  input  wire logic [1:0]         i_overtravel_stop_select,
  input  wire logic [2:0]         i_group_two_stop_select,
  input  wire logic [P_SPD_W-1:0] i_motor_speed,
  input  wire logic [8:0]         i_motor_max_torque,
  output logic                    o_motor_power,
  output logic                    o_dynamic_brake,
  output logic                    o_reverse_brake,
  output logic                    o_speed_ref_zero,
  output logic                    o_soft_start_bypass,
  output logic [8:0]              o_torque_limit,
  output logic                    o_zero_clamp,
  output logic                    o_brake_release_out,
  output logic [1:0]              o_out_pin,
  output logic                    o_warning,
  output logic                    o_irq
);
  localparam int TW = 16;

  // pin synchronisers
  logic [4:0] pin_meta;
  logic [4:0] pin_sync;
  logic [6:0] sel_meta;
  logic [6:0] sel_sync;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pin_meta <= '0;
      pin_sync <= '0;
      sel_meta <= '0;
      sel_sync <= '0;
    end else if (i_ce) begin
      pin_meta <= {i_alarm_group_one, i_alarm_group_two, i_safe_state,
                   i_overtravel, 1'b0};
      pin_sync <= pin_meta;
      sel_meta <= {i_group_two_stop_select, i_overtravel_stop_select,
                   i_group_one_stop_select};
      sel_sync <= sel_meta;
    end
  end
  wire logic alm1_s = pin_sync[4];
  wire logic alm2_s = pin_sync[3];
  wire logic safe_s = pin_sync[2];
  wire logic ot_s   = pin_sync[1];

  // RULE_17 straps caught once
  logic [1:0] cfg_cnt;
  logic       cfg_done;
  logic [1:0] g1_sel;
  logic [1:0] ot_sel;
  logic [2:0] g2_sel;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cfg_cnt  <= '0;
      cfg_done <= 1'b0;
      g1_sel   <= '0;
      ot_sel   <= '0;
      g2_sel   <= '0;
    end else if (i_ce && !cfg_done) begin
      if (cfg_cnt == 2'(MSB_CFG_SETTLE)) begin
        cfg_done <= 1'b1;
        g1_sel   <= sel_sync[1:0];
        ot_sel   <= sel_sync[3:2];
        g2_sel   <= sel_sync[6:4];
      end else begin
        cfg_cnt <= cfg_cnt + 2'h1;
      end
    end
  end

  // register file
  logic                servo_on_cmd;
  logic signed [15:0]  son_wait;
  logic [8:0]          soff_wait;
  logic [6:0]          brk_spd;
  logic [6:0]          brk_wait;
  logic [8:0]          rb_trq;
  logic [7:0]          pin_assign;
  logic [MSB_IRQ_W-1:0] irq_stat;
  logic [MSB_IRQ_W-1:0] irq_mask;
  logic [MSB_IRQ_W-1:0] irq_ev;
  logic                alm1_lat;
  logic                alm2_lat;
  msb_state_t          state;
  msb_stop_t           stop_meth;
  msb_post_t           post_meth;

  wire logic acc_wr = i_psel && i_penable && o_pready && i_pwrite;
  wire logic signed [15:0] wd16 = i_pwdata[15:0];

  // RULE_14 clamped parameter writes
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      servo_on_cmd <= 1'b0;
      son_wait     <= MSB_SON_WAIT_RST;
      soff_wait    <= MSB_SOFF_WAIT_RST;
      brk_spd      <= MSB_BRK_SPD_RST;
      brk_wait     <= MSB_BRK_WAIT_RST;
      rb_trq       <= MSB_RB_TRQ_RST;
      pin_assign   <= MSB_PIN_ASSIGN_RST;
      irq_mask     <= '0;
    end else if (i_ce && acc_wr) begin
      case (i_paddr)
        MSB_OFF_CTRL: servo_on_cmd <= i_pwdata[MSB_CTRL_SON_BIT];
        MSB_OFF_SON_WAIT:
          son_wait <= (wd16 > MSB_SON_WAIT_MAX) ? MSB_SON_WAIT_MAX :
                      (wd16 < MSB_SON_WAIT_MIN) ? MSB_SON_WAIT_MIN : wd16;
        MSB_OFF_SOFF_WAIT:
          soff_wait <= (i_pwdata[31:0] > 32'(MSB_SOFF_WAIT_MAX)) ?
                       MSB_SOFF_WAIT_MAX : i_pwdata[8:0];
        MSB_OFF_BRK_SPD:
          brk_spd <= (i_pwdata > 32'(MSB_BRK_SPD_MAX)) ? MSB_BRK_SPD_MAX :
                     (i_pwdata < 32'(MSB_BRK_SPD_MIN)) ? MSB_BRK_SPD_MIN :
                     i_pwdata[6:0];
        MSB_OFF_BRK_WAIT:
          brk_wait <= (i_pwdata > 32'(MSB_BRK_WAIT_MAX)) ? MSB_BRK_WAIT_MAX :
                      (i_pwdata < 32'(MSB_BRK_WAIT_MIN)) ? MSB_BRK_WAIT_MIN :
                      i_pwdata[6:0];
        MSB_OFF_RB_TORQUE:
          rb_trq <= (i_pwdata > 32'(MSB_RB_TRQ_MAX)) ? MSB_RB_TRQ_MAX :
                    i_pwdata[8:0];
        MSB_OFF_PIN_ASSIGN: pin_assign <= i_pwdata[7:0];
        MSB_OFF_IRQ_MASK:   irq_mask <= i_pwdata[MSB_IRQ_W-1:0];
        default: ;
      endcase
    end
  end

  // RULE_06 alarms latch until manual reset, set wins
  wire logic alm_rst_wr = acc_wr && (i_paddr == MSB_OFF_ALARM_RST);
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      alm1_lat <= 1'b0;
      alm2_lat <= 1'b0;
    end else if (i_ce) begin
      alm1_lat <= alm1_s || (alm1_lat && !(alm_rst_wr && i_pwdata[0]));
      alm2_lat <= alm2_s || (alm2_lat && !(alm_rst_wr && i_pwdata[1]));
    end
  end

  // sticky status, write one to clear, set wins
  wire logic stat_wr = acc_wr && (i_paddr == MSB_OFF_IRQ_STAT);
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      irq_stat <= '0;
      o_irq    <= 1'b0;
    end else if (i_ce) begin
      irq_stat <= irq_ev |
                  (irq_stat & ~(stat_wr ? i_pwdata[MSB_IRQ_W-1:0] : '0));
      o_irq    <= |(irq_stat & irq_mask);
    end
  end

  // apb answer, one cycle after setup
  logic [31:0] rd_data;
  logic        rd_err;
  always_comb begin
    rd_data = 32'h0;
    rd_err  = 1'b0;
    case (i_paddr)
      MSB_OFF_CTRL:       rd_data = {31'h0, servo_on_cmd};
      MSB_OFF_SON_WAIT:   rd_data = 32'(son_wait);
      MSB_OFF_SOFF_WAIT:  rd_data = {23'h0, soff_wait};
      MSB_OFF_BRK_SPD:    rd_data = {25'h0, brk_spd};
      MSB_OFF_BRK_WAIT:   rd_data = {25'h0, brk_wait};
      MSB_OFF_RB_TORQUE:  rd_data = {23'h0, rb_trq};
      MSB_OFF_PIN_ASSIGN: rd_data = {24'h0, pin_assign};
      MSB_OFF_STATUS:
        rd_data = {10'h0, g2_sel, ot_sel, g1_sel, post_meth, stop_meth,
                   o_warning, alm2_lat, alm1_lat, o_brake_release_out,
                   o_motor_power, state};
      MSB_OFF_IRQ_STAT:   rd_data = {28'h0, irq_stat};
      MSB_OFF_IRQ_MASK:   rd_data = {28'h0, irq_mask};
      MSB_OFF_ALARM_RST:  rd_data = 32'h0;
      default:            rd_err  = 1'b1;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_pready  <= 1'b0;
      o_prdata  <= 32'h0;
      o_pslverr <= 1'b0;
    end else if (i_ce) begin
      o_pready  <= i_psel && !i_penable;
      o_prdata  <= (i_psel && !i_penable && !i_pwrite) ? rd_data : 32'h0;
      o_pslverr <= i_psel && !i_penable && rd_err;
    end
  end

  // millisecond tick
  logic [31:0] pre_cnt;
  logic        tick;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pre_cnt <= '0;
      tick    <= 1'b0;
    end else if (i_ce) begin
      tick    <= (pre_cnt == 32'(P_TICK_CYCLES - 1));
      pre_cnt <= (pre_cnt == 32'(P_TICK_CYCLES - 1)) ? '0 : pre_cnt + 32'h1;
    end
  end

  logic          tmr_load;
  logic [TW-1:0] tmr_val;
  logic          tmr_exp;
  msb_timer #(.W(TW)) u_timer (
    .i_clk      (i_clk),
    .i_rst_n    (i_rst_n),
    .i_ce       (i_ce),
    .i_tick     (tick),
    .i_load     (tmr_load),
    .i_load_val (tmr_val),
    .o_expired  (tmr_exp)
  );

  // RULE_18 absolute speed against threshold
  wire logic signed [P_SPD_W:0] spd_ext = {i_motor_speed[P_SPD_W-1],
                                          i_motor_speed};
  wire logic [P_SPD_W:0] spd_abs = spd_ext[P_SPD_W] ? P_SPD_W'(0) - spd_ext
                                                    : spd_ext;
  wire logic slow = spd_abs < (P_SPD_W+1)'(brk_spd);

  // causes; group-two select 5 only warns
  wire logic c_g1   = alm1_lat || safe_s;
  wire logic g2_wrn = (g2_sel == MSB_G2_WARN_ONLY);
  wire logic c_g2   = alm2_lat && !g2_wrn;
  wire logic c_ot   = ot_s;
  wire logic c_any  = c_g1 || c_g2 || c_ot || !servo_on_cmd;

  // method decode for the highest cause
  msb_stop_t sel_stop;
  msb_post_t sel_post;
  always_comb begin
    sel_stop = MSB_STOP_DB;
    sel_post = MSB_POST_COAST;
    if (c_g2 && !c_g1) begin
      // RULE_03 group-two table
      case (g2_sel)
        3'd1: sel_post = MSB_POST_DB;
        3'd2: sel_stop = MSB_STOP_COAST;
        3'd3: begin sel_stop = MSB_STOP_RB; sel_post = MSB_POST_DB; end
        3'd4: sel_stop = MSB_STOP_RB;
        default: ;
      endcase
    end else if (c_ot && !c_g1) begin
      // RULE_02 overtravel table
      case (ot_sel)
        2'd1: sel_post = MSB_POST_DB;
        2'd2: begin sel_stop = MSB_STOP_RB; sel_post = MSB_POST_ZC; end
        2'd3: sel_stop = MSB_STOP_RB;
        default: ;
      endcase
    end else begin
      // RULE_01 group-one, safe state and servo-off table
      case (g1_sel)
        2'd1: sel_post = MSB_POST_DB;
        2'd2: sel_stop = MSB_STOP_COAST;
        default: ;
      endcase
    end
  end

  // overtravel alone keeps the brake free
  wire logic brk_cause = c_g1 || c_g2 || !servo_on_cmd;
  wire logic [TW-1:0] son_mag = son_wait[15] ? TW'(-son_wait)
                                             : TW'(son_wait);

  // sequencer, brake release and power
  logic power;
  logic brake_rel;
  logic soff_alarm;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state     <= MSB_ST_IDLE;
      stop_meth <= MSB_STOP_DB;
      post_meth <= MSB_POST_COAST;
      power     <= 1'b0;
      brake_rel <= 1'b0;
      tmr_load  <= 1'b0;
      tmr_val   <= '0;
      irq_ev    <= '0;
    end else if (i_ce) begin
      tmr_load <= 1'b0;
      irq_ev   <= '0;
      irq_ev[MSB_IRQ_WARNING] <= alm2_s && !alm2_lat && g2_wrn;
      case (state)
        MSB_ST_IDLE: begin
          power     <= 1'b0;
          brake_rel <= 1'b0;
          if (cfg_done && !c_any) begin
            state    <= MSB_ST_SON;
            tmr_load <= 1'b1;
            tmr_val  <= son_mag;
            // RULE_10 positive wait releases first
            brake_rel <= !son_wait[15];
            // RULE_11 negative wait powers first
            power     <= son_wait[15];
          end
        end
        MSB_ST_SON: begin
          if (c_any) begin
            state     <= MSB_ST_STOP;
            stop_meth <= sel_stop;
            post_meth <= sel_post;
            power     <= (sel_stop == MSB_STOP_RB);
            tmr_load  <= 1'b1;
            tmr_val   <= TW'(brk_wait) * TW'(MSB_UNIT_10MS);
            irq_ev[MSB_IRQ_STOP_START] <= 1'b1;
          end else if (tmr_exp && !tmr_load) begin
            power     <= 1'b1;
            brake_rel <= 1'b1;
            state     <= MSB_ST_RUN;
          end
        end
        MSB_ST_RUN: begin
          if (!servo_on_cmd && !c_g1 && !c_g2 && !c_ot && slow) begin
            // RULE_09 stopped servo-off: brake now, power later
            state     <= MSB_ST_SOFF;
            brake_rel <= 1'b0;
            tmr_load  <= 1'b1;
            tmr_val   <= TW'(soff_wait) * TW'(MSB_UNIT_10MS);
            irq_ev[MSB_IRQ_BRAKE_ON] <= brake_rel;
          end else if (c_any) begin
            // RULE_13 start the stop
            state     <= MSB_ST_STOP;
            stop_meth <= sel_stop;
            post_meth <= sel_post;
            power     <= (sel_stop == MSB_STOP_RB);
            tmr_load  <= 1'b1;
            tmr_val   <= TW'(brk_wait) * TW'(MSB_UNIT_10MS);
            irq_ev[MSB_IRQ_STOP_START] <= 1'b1;
          end
        end
        MSB_ST_SOFF: begin
          if (c_g1 || c_g2) begin
            // RULE_12 alarm drops power at once
            power <= 1'b0;
            state <= MSB_ST_IDLE;
          end else if (tmr_exp && !tmr_load) begin
            power <= 1'b0;
            state <= MSB_ST_IDLE;
          end
        end
        MSB_ST_STOP: begin
          // RULE_07 brake engages for servo-off or alarm
          if (brk_cause && brake_rel && (slow || (tmr_exp && !tmr_load))) begin
            brake_rel <= 1'b0;
            irq_ev[MSB_IRQ_BRAKE_ON] <= 1'b1;
          end
          if (slow) begin
            state <= MSB_ST_POST;
            power <= (post_meth == MSB_POST_ZC);
            irq_ev[MSB_IRQ_STOP_DONE] <= 1'b1;
          end
        end
        MSB_ST_POST: begin
          if (brk_cause && brake_rel) begin
            brake_rel <= 1'b0;
            irq_ev[MSB_IRQ_BRAKE_ON] <= 1'b1;
          end
          if (!c_g1 && !c_g2 && !c_ot) begin
            state <= (post_meth == MSB_POST_ZC && servo_on_cmd) ?
                     MSB_ST_RUN : MSB_ST_IDLE;
          end
        end
        default: state <= MSB_ST_IDLE;
      endcase
    end
  end

  // registered drive outputs
  wire logic rb_act = (state == MSB_ST_STOP) && (stop_meth == MSB_STOP_RB);
  wire logic [8:0] rb_lim = (rb_trq < i_motor_max_torque) ? rb_trq
                                                         : i_motor_max_torque;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_motor_power       <= 1'b0;
      o_dynamic_brake     <= 1'b0;
      o_reverse_brake     <= 1'b0;
      o_speed_ref_zero    <= 1'b0;
      o_soft_start_bypass <= 1'b0;
      o_torque_limit      <= '0;
      o_zero_clamp        <= 1'b0;
      o_brake_release_out <= 1'b0;
      o_out_pin           <= '0;
      o_warning           <= 1'b0;
    end else if (i_ce) begin
      o_motor_power   <= power;
      o_dynamic_brake <= ((state == MSB_ST_STOP) &&
                          (stop_meth == MSB_STOP_DB)) ||
                         ((state == MSB_ST_POST) &&
                          (post_meth == MSB_POST_DB)) ||
                         ((state == MSB_ST_IDLE) && (g1_sel == 2'd1));
      o_reverse_brake <= rb_act;
      // RULE_04 zero reference, no soft start
      o_speed_ref_zero    <= rb_act;
      o_soft_start_bypass <= rb_act;
      // RULE_05 reverse brake torque cap
      o_torque_limit <= rb_act ? rb_lim : i_motor_max_torque;
      // RULE_16 position loop held at zero reference
      o_zero_clamp <= (state == MSB_ST_POST) && (post_meth == MSB_POST_ZC);
      o_brake_release_out <= brake_rel;
      // RULE_08 routed where field is 4
      o_out_pin[0] <= (pin_assign[3:0] == MSB_PIN_BRAKE) && brake_rel;
      o_out_pin[1] <= (pin_assign[7:4] == MSB_PIN_BRAKE) && brake_rel;
      // RULE_06 held group-two warning
      o_warning <= alm2_lat && g2_wrn;
    end
  end
endmodule
`default_nettype wire

//--- verilog/msb_pkg.sv
package msb_pkg;
  // register byte offsets
  localparam logic [7:0] MSB_OFF_CTRL       = 8'h00;
  localparam logic [7:0] MSB_OFF_SON_WAIT   = 8'h04;
  localparam logic [7:0] MSB_OFF_SOFF_WAIT  = 8'h08;
  localparam logic [7:0] MSB_OFF_BRK_SPD    = 8'h0C;
  localparam logic [7:0] MSB_OFF_BRK_WAIT   = 8'h10;
  localparam logic [7:0] MSB_OFF_RB_TORQUE  = 8'h14;
  localparam logic [7:0] MSB_OFF_PIN_ASSIGN = 8'h18;
  localparam logic [7:0] MSB_OFF_STATUS     = 8'h1C;
  localparam logic [7:0] MSB_OFF_IRQ_STAT   = 8'h20;
  localparam logic [7:0] MSB_OFF_IRQ_MASK   = 8'h24;
  localparam logic [7:0] MSB_OFF_ALARM_RST  = 8'h28;

  // parameter limits and reset values
  localparam logic signed [15:0] MSB_SON_WAIT_MAX  = 16'sd2000;
  localparam logic signed [15:0] MSB_SON_WAIT_MIN  = -16'sd2000;
  localparam logic signed [15:0] MSB_SON_WAIT_RST  = 16'sd0;
  localparam logic [8:0]  MSB_SOFF_WAIT_MAX = 9'd500;
  localparam logic [8:0]  MSB_SOFF_WAIT_RST = 9'd0;
  localparam logic [6:0]  MSB_BRK_SPD_MIN   = 7'd10;
  localparam logic [6:0]  MSB_BRK_SPD_MAX   = 7'd100;
  localparam logic [6:0]  MSB_BRK_SPD_RST   = 7'd100;
  localparam logic [6:0]  MSB_BRK_WAIT_MIN  = 7'd10;
  localparam logic [6:0]  MSB_BRK_WAIT_MAX  = 7'd100;
  localparam logic [6:0]  MSB_BRK_WAIT_RST  = 7'd50;
  localparam logic [8:0]  MSB_RB_TRQ_MAX    = 9'd350;
  localparam logic [8:0]  MSB_RB_TRQ_RST    = 9'd300;
  localparam logic [3:0]  MSB_PIN_BRAKE     = 4'h4;
  localparam logic [7:0]  MSB_PIN_ASSIGN_RST = 8'h00;
  localparam logic [2:0]  MSB_G2_WARN_ONLY  = 3'd5;

  // field positions
  localparam int MSB_CTRL_SON_BIT   = 0;
  localparam int MSB_IRQ_STOP_START = 0;
  localparam int MSB_IRQ_BRAKE_ON   = 1;
  localparam int MSB_IRQ_WARNING    = 2;
  localparam int MSB_IRQ_STOP_DONE  = 3;
  localparam int MSB_IRQ_W          = 4;

  // timing: one timer tick is one millisecond
  localparam int MSB_CLK_KHZ      = 125000;
  localparam int MSB_TICK_MS      = 1;
  localparam int MSB_TICK_CYCLES  = MSB_CLK_KHZ * MSB_TICK_MS;
  localparam int MSB_UNIT_10MS    = 10;  // ticks per 10 ms unit
  localparam int MSB_CFG_SETTLE   = 2;   // edges before straps are caught

  // stop methods and post-stop states
  typedef enum logic [1:0] {
    MSB_STOP_DB    = 2'h0,
    MSB_STOP_COAST = 2'h1,
    MSB_STOP_RB    = 2'h2
  } msb_stop_t;

  typedef enum logic [1:0] {
    MSB_POST_COAST = 2'h0,
    MSB_POST_DB    = 2'h1,
    MSB_POST_ZC    = 2'h2
  } msb_post_t;

  typedef enum logic [5:0] {
    MSB_ST_IDLE  = 6'h01,
    MSB_ST_SON   = 6'h02,
    MSB_ST_RUN   = 6'h04,
    MSB_ST_SOFF  = 6'h08,
    MSB_ST_STOP  = 6'h10,
    MSB_ST_POST  = 6'h20
  } msb_state_t;
endpackage

//--- verilog/msb_timer.sv
`timescale 1ns/1ns
`default_nettype none
// millisecond down counter, expired at zero
module msb_timer #(
  parameter int W = 16
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst_n,
  input  wire logic         i_ce,
  input  wire logic         i_tick,
  input  wire logic         i_load,
  input  wire logic [W-1:0] i_load_val,
  output logic              o_expired
);
  logic [W-1:0] count;

  // load wins over a tick in the same cycle
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      count <= '0;
    end else if (i_ce) begin
      if (i_load) begin
        count <= i_load_val;
      end else if (i_tick && count != '0) begin
        count <= count - 1'b1;
      end
    end
  end

  assign o_expired = (count == '0);
endmodule
`default_nettype wire

//--- dv/msb_top_properties.sv
`timescale 1ns/1ns
`default_nettype none
// sequencer port checks
module msb_top_properties (
  input wire logic        i_clk,
  input wire logic        i_rst_n,
  input wire logic        i_psel,
  input wire logic        i_penable,
  input wire logic        i_alarm_group_one,
  input wire logic [15:0] i_motor_speed,
  input wire logic [8:0]  i_motor_max_torque,
  input wire logic        o_pready,
  input wire logic        o_motor_power,
  input wire logic        o_reverse_brake,
  input wire logic        o_speed_ref_zero,
  input wire logic        o_soft_start_bypass,
  input wire logic [8:0]  o_torque_limit,
  input wire logic        o_zero_clamp,
  input wire logic        o_brake_release_out,
  input wire logic [1:0]  o_out_pin
);
  logic slow;
  // under the lowest threshold
  assign slow = ($signed(i_motor_speed) < 16'sh000A) &&
                ($signed(i_motor_speed) > -16'sh000A);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  sequence s_setup; i_psel && !i_penable; endsequence
  sequence s_slow_alarm; $rose(i_alarm_group_one) && slow; endsequence
  AST_APB_ANSWER: assert property (
    s_setup |=> o_pready) else $error("no ready");
  AST_REF_ZERO: assert property (
    o_speed_ref_zero == o_reverse_brake) else $error("ref not zeroed");
  AST_SOFT_BYPASS: assert property (
    o_soft_start_bypass == o_reverse_brake) else $error("ramp kept");
  AST_RB_TORQUE: assert property (
    o_reverse_brake |-> o_torque_limit <= 9'h15E &&
    o_torque_limit <= $past(i_motor_max_torque)) else $error("torque cap");
  AST_PIN_ROUTE: assert property (
    |o_out_pin |-> o_brake_release_out || $past(o_brake_release_out))
    else $error("pin without release");
  AST_ALARM_POWER: assert property (
    $rose(i_alarm_group_one) |-> ##[1:8] !o_motor_power)
    else $error("power kept");
  AST_ALARM_BRAKE: assert property (
    s_slow_alarm |-> ##[1:8] !o_brake_release_out)
    else $error("brake kept");
  AST_ZERO_CLAMP: assert property (
    o_zero_clamp |-> !o_reverse_brake) else $error("clamp while braking");
endmodule
`default_nettype wire

//--- dv/msb_host_model.sv
`timescale 1ns/1ns
`default_nettype none
// host: apb master for servo commands
module msb_host_model #(
  parameter int P_MS = 10
) (
  input  wire logic        i_clk,
  input  wire logic        i_pready,
  input  wire logic [31:0] i_prdata,
  output logic             o_psel,
  output logic             o_penable,
  output logic             o_pwrite,
  output logic [7:0]       o_paddr,
  output logic [31:0]      o_pwdata
);
  // idle bus
  initial begin
    o_psel = 1'b0;
    o_penable = 1'b0;
    o_pwrite = 1'b0;
    o_paddr = 8'h00;
    o_pwdata = 32'h0;
  end
  // setup, access until ready, then release
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] v, output logic [31:0] q,
                      output logic h);
    h = 1'b1;
    @(posedge i_clk);
    o_psel <= 1'b1;
    o_pwrite <= w;
    o_paddr <= a;
    o_pwdata <= v;
    @(posedge i_clk);
    o_penable <= 1'b1;
    for (int n = 0; n < 16 && h; n++) begin
      @(posedge i_clk);
      h = (i_pready !== 1'b1);
    end
    q = i_prdata;
    o_psel <= 1'b0;
    o_penable <= 1'b0;
    o_paddr <= ~a;
    o_pwdata <= ~v;
  endtask
  task automatic hold_off(input int brk_ms);
    repeat ((50 + brk_ms) * P_MS) @(posedge i_clk);
  endtask
endmodule
`default_nettype wire

//--- dv/test_motor_stop_brake_sequencer.sv
`timescale 1ns/1ns
`default_nettype none
module test_motor_stop_brake_sequencer;
  import msb_pkg::*;
  localparam int MS = 10;  // cycles per timer tick
  localparam int BRK = 0, PWR = 1, RBK = 2, ZCL = 3, WRN = 4, IRQS = 5;
  logic        clk, rst_n, psel, penable, pwrite, pready, pslverr;
  logic        al1, al2, ot, safe, power, rb, srz, ssb, zc, brk, warn, irq;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q;
  logic [15:0] speed;
  logic [8:0]  mtrq, trq;
  logic [1:0]  pin;
  int          n_mismatch, samples_checked, d;
  msb_top #(.P_TICK_CYCLES(MS)) u_dut (
    .i_clk(clk), .i_rst_n(rst_n), .i_ce(1'b1), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_pready(pready), .o_prdata(prdata),
    .o_pslverr(pslverr), .i_alarm_group_one(al1),
    .i_alarm_group_two(al2), .i_safe_state(safe), .i_overtravel(ot),
    .i_group_one_stop_select(2'h0), .i_overtravel_stop_select(2'h2),
    .i_group_two_stop_select(3'h5), .i_motor_speed(speed),
    .i_motor_max_torque(mtrq), .o_motor_power(power),
    .o_dynamic_brake(), .o_reverse_brake(rb), .o_speed_ref_zero(srz),
    .o_soft_start_bypass(ssb), .o_torque_limit(trq), .o_zero_clamp(zc),
    .o_brake_release_out(brk), .o_out_pin(pin), .o_warning(warn),
    .o_irq(irq));
  msb_host_model #(.P_MS(MS)) u_host (
    .i_clk(clk), .i_pready(pready), .i_prdata(prdata), .o_psel(psel),
    .o_penable(penable), .o_pwrite(pwrite), .o_paddr(paddr),
    .o_pwdata(pwdata));
  // 125 MHz clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // compare one value and count it
  task automatic check(input logic [31:0] s, x);
    samples_checked++;
    if (s !== x) begin
      n_mismatch++;
      $display("Error %0t: got %h want %h", $time, s, x);
    end
  endtask
  // counts and verdict, then stop
  task automatic complete_run();
    $display("checked %0d, mismatched %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // one access; a hang ends the run
  task automatic acc(input logic w, input logic [7:0] a,
                     input logic [31:0] v);
    logic h;
    u_host.xfer(w, a, v, q, h);
    if (h) begin
      n_mismatch++;
      complete_run();
    end
  endtask
  // bounded wait for an output level
  task automatic wt(input int k, input logic v);
    logic [5:0] s;
    for (d = 0; d < 4000; d++) begin
      s = {irq, warn, zc, rb, power, brk};
      if (s[k] === v) break;
      @(posedge clk);
    end
    if (d == 4000) begin
      n_mismatch++;
      complete_run();
    end
  endtask
  // reset, then scenarios
  initial begin
    {rst_n, al1, al2, ot, safe} = 5'h0;
    speed = 16'h0;
    mtrq = 9'h0FA;  // 250 percent
    {n_mismatch, samples_checked} = 0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    acc(1'b0, MSB_OFF_BRK_SPD, 32'h0);
    check(q, 32'h64);
    acc(1'b0, MSB_OFF_BRK_WAIT, 32'h0);
    check(q, 32'h32);
    acc(1'b1, MSB_OFF_BRK_SPD, 32'h5);
    acc(1'b0, MSB_OFF_BRK_SPD, 32'h0);
    check(q, 32'hA);
    acc(1'b1, MSB_OFF_BRK_SPD, 32'h14);
    acc(1'b0, 8'h30, 32'h0);
    check(pslverr, 32'h1);
    $display("register test done");
    acc(1'b1, MSB_OFF_PIN_ASSIGN, 32'h4);
    acc(1'b1, MSB_OFF_SON_WAIT, 32'h3);
    acc(1'b1, MSB_OFF_IRQ_MASK, 32'h1);
    acc(1'b1, MSB_OFF_CTRL, 32'h1);
    wt(BRK, 1'b1);
    wt(PWR, 1'b1);
    check(d >= 2*MS && d <= 3*MS+4, 32'h1);
    check(pin, 32'h1);
    u_host.hold_off(10);
    acc(1'b1, MSB_OFF_SOFF_WAIT, 32'h2);
    acc(1'b1, MSB_OFF_CTRL, 32'h0);
    wt(BRK, 1'b0);
    check(d <= 8, 32'h1);
    wt(PWR, 1'b0);
    check(d >= 19*MS && d <= 21*MS, 32'h1);
    acc(1'b1, MSB_OFF_SON_WAIT, 32'hFFFF_FFFD);
    acc(1'b1, MSB_OFF_CTRL, 32'h1);
    wt(PWR, 1'b1);
    wt(BRK, 1'b1);
    check(d >= 2*MS && d <= 3*MS+4, 32'h1);
    $display("servo test done");
    al2 <= 1'b1;
    wt(WRN, 1'b1);
    check(power, 32'h1);
    al2 <= 1'b0;
    repeat (20) @(posedge clk);
    check(warn, 32'h1);
    acc(1'b1, MSB_OFF_ALARM_RST, 32'h2);
    wt(WRN, 1'b0);
    speed <= 16'h01F4;  // 500 rpm
    ot <= 1'b1;
    wt(RBK, 1'b1);
    check(trq, 32'hFA);
    check({30'h0, srz, ssb}, 32'h3);
    speed <= 16'h0;
    wt(ZCL, 1'b1);
    check(rb, 32'h0);
    ot <= 1'b0;
    wt(ZCL, 1'b0);
    speed <= 16'hFE0C;  // -500 rpm
    acc(1'b1, MSB_OFF_CTRL, 32'h0);
    wt(PWR, 1'b0);
    repeat (100) @(posedge clk);
    check(brk, 32'h1);
    speed <= 16'hFFF1;  // -15 rpm
    wt(BRK, 1'b0);
    check(d <= 8, 32'h1);
    $display("stop test done");
    speed <= 16'h0;
    acc(1'b1, MSB_OFF_CTRL, 32'h1);
    wt(BRK, 1'b1);
    acc(1'b1, MSB_OFF_IRQ_STAT, 32'hF);
    repeat (2) @(posedge clk);
    check(irq, 32'h0);
    al1 <= 1'b1;
    wt(PWR, 1'b0);
    check(d <= 8, 32'h1);
    wt(IRQS, 1'b1);
    acc(1'b1, MSB_OFF_IRQ_MASK, 32'h0);
    repeat (2) @(posedge clk);
    check(irq, 32'h0);
    $display("alarm test done");
    complete_run();
  end
endmodule
bind msb_top msb_top_properties u_chk (.*);
`default_nettype wire
